//--- hdl/agent_message_handler.v
// Inter-agent message sender and receiver with an Avalon-MM register slave
`timescale 1ns/1ps
`include "agent_message_defs.vh"

module agent_message_handler (
	input wire clock_i, // 100 MHz clock
	input wire rst_n_i, // Async reset, active low
	input wire [3:0] avs_address_i, // Word address
	input wire avs_read_i, // Read request
	input wire avs_write_i, // Write request
	input wire [31:0] avs_writedata_i, // Write data
	output reg [31:0] avs_readdata_o, // Read data
	output reg avs_waitrequest_o, // Stall
	output reg xfer_req_o, // Quad transfer request to bus
	output reg [31:0] xfer_addr_o, // Encoded receiver address
	output reg [127:0] xfer_data_o, // Four message words, word 0 low
	input wire xfer_done_i, // Transfer finished, one cycle
	input wire xfer_ack_i, // Ack with done, low means nack
	input wire first_interrupt_pin_n_i, // Request pin, active low
	output reg fetch_req_o, // Fetch incoming message from bus
	input wire fetch_done_i, // Fetched message valid, one cycle
	input wire [127:0] fetch_data_i, // Fetched message words
	output reg servicing_o, // Handling a message
	output reg [4:0] exec_priority_o, // Current priority to arbiter
	output reg [9:0] agent_id_o, // Own receiver id
	output reg pin_irq_o, // Ordinary interrupt from first pin
	output reg intr_req_o, // Service interrupt now, pulse
	output reg [7:0] intr_vector_o, // Vector served
	output reg cache_purge_o, // Invalidate instruction cache, pulse
	output reg init_start_o, // Start initialisation, pulse
	output reg frozen_o, // Stopped state
	output reg reinit_o, // Reinitialise, pulse
	output reg [31:0] ip_o, // Start instruction pointer
	output reg [31:0] bp0_o, // Breakpoint 0 address
	output reg [31:0] bp1_o, // Breakpoint 1 address
	output reg [1:0] bp_en_o, // Breakpoint enables
	output reg mem_wr_o, // Memory word write, pulse
	output reg [31:0] mem_addr_o, // Write address
	output reg [31:0] mem_data_o // Write data
);

////////////////////////////////////////////////////////////////////////
localparam [2:0] S_IDLE = 3'b001;
localparam [2:0] S_BUS = 3'b010;
localparam [2:0] S_FIN = 3'b100;

localparam [4:0] R_IDLE = 5'b00001;
localparam [4:0] R_FETCH = 5'b00010;
localparam [4:0] R_EXEC = 5'b00100;
localparam [4:0] R_STORE = 5'b01000;
localparam [4:0] R_DONE = 5'b10000;

function in_range;
	input [31:0] a;
	begin
		in_range = (a >= `ADDR_MIN) && (a <= `ADDR_MAX);
	end
endfunction

function [5:0] best_pending;
	input [31:0] p;
	integer i;
	begin
		best_pending = 6'h00;
		for (i = 0; i < 32; i = i + 1) begin
			if (p[i]) begin
				best_pending = {1'b1, i[4:0]};
			end
		end
	end
endfunction

////////////////////////////////////////////////////////////////////////
reg [7:0] pin_vector;
reg [31:0] agent_addr;
reg [31:0] send_addr;
reg [31:0] send_w [0:3];
reg [2:0] cond_code;
reg [2:0] send_state;
reg [4:0] rx_state;
reg [31:0] msg [0:3];
reg [31:0] sat;
reg [31:0] processor_control_block;
reg [31:0] pend;
reg [7:0] pend_vec [0:31];
reg [31:0] rdata;

wire rd_take = avs_read_i & avs_waitrequest_o;
wire wr_take = avs_write_i & ~avs_waitrequest_o;
wire go_wr = avs_write_i & (avs_address_i == `REG_GO);
wire go_start = go_wr & avs_waitrequest_o & (send_state == S_IDLE);
wire send_internal = (send_addr == `ADDR_INTERNAL);
wire int_load = go_start & send_internal & (rx_state == R_IDLE);
wire [7:0] msg_type = msg[0][`MSG_TYPE_MSB:`MSG_TYPE_LSB];
wire [7:0] msg_field1 = msg[0][`MSG_FIELD1_MSB:`MSG_FIELD1_LSB];
wire [4:0] field1_prio = msg_field1[`VEC_PRIO_MSB:`VEC_PRIO_LSB];
wire [5:0] best = best_pending(pend);
wire pin_req = ~first_interrupt_pin_n_i;
wire [9:0] tgt_id = send_addr[`ADDR_ID_MSB:`ADDR_ID_LSB];
wire [4:0] tgt_prio = send_addr[`ADDR_PRIO_MSB:`ADDR_PRIO_LSB];

////////////////////////////////////////////////////////////////////////
// Register read mux
always @* begin
	case (avs_address_i)
	`REG_CTRL: rdata = {19'h0, exec_priority_o, pin_vector};
	`REG_AGENT_ADDR: rdata = agent_addr;
	`REG_SEND_ADDR: rdata = send_addr;
	`REG_SEND_W0: rdata = send_w[0];
	`REG_SEND_W1: rdata = send_w[1];
	`REG_SEND_W2: rdata = send_w[2];
	`REG_SEND_W3: rdata = send_w[3];
	`REG_STATUS: rdata = {11'h0, tgt_prio, tgt_id, servicing_o, frozen_o, send_state != S_IDLE, cond_code};
	`REG_BP0: rdata = bp0_o;
	`REG_BP1: rdata = bp1_o;
	`REG_SAT: rdata = sat;
	`REG_PROCESSOR_CONTROL_BLOCK: rdata = processor_control_block;
	default: rdata = 32'h00000000;
	endcase
end

// One wait cycle per access; the go write stalls until the send is over
always @(posedge clock_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		avs_waitrequest_o <= 1'b1;
		avs_readdata_o <= 32'h00000000;
	end else if (!avs_waitrequest_o) begin
		avs_waitrequest_o <= 1'b1;
	end else if (rd_take || (avs_write_i && !go_wr)) begin
		avs_waitrequest_o <= 1'b0;
		avs_readdata_o <= rdata;
	end else if (go_wr && send_state == S_FIN) begin
		avs_waitrequest_o <= 1'b0;
	end
end

// Software-written registers
always @(posedge clock_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		pin_vector <= 8'h00;
		exec_priority_o <= 5'h00;
		agent_addr <= `ADDR_MIN;
		agent_id_o <= 10'h000;
		send_addr <= 32'h00000000;
		send_w[0] <= 32'h00000000;
		send_w[1] <= 32'h00000000;
		send_w[2] <= 32'h00000000;
		send_w[3] <= 32'h00000000;
	end else begin
		agent_id_o <= agent_addr[`ADDR_ID_MSB:`ADDR_ID_LSB];
		if (wr_take) begin
			case (avs_address_i)
			`REG_CTRL: begin
				pin_vector <= avs_writedata_i[`CTRL_VEC_MSB:`CTRL_VEC_LSB];
				exec_priority_o <= avs_writedata_i[`CTRL_PRIO_MSB:`CTRL_PRIO_LSB];
			end
			`REG_AGENT_ADDR: begin
				if (in_range(avs_writedata_i)) begin
					agent_addr <= avs_writedata_i;
				end
			end
			`REG_SEND_ADDR: send_addr <= avs_writedata_i;
			`REG_SEND_W0: send_w[0] <= avs_writedata_i;
			`REG_SEND_W1: send_w[1] <= avs_writedata_i;
			`REG_SEND_W2: send_w[2] <= avs_writedata_i;
			`REG_SEND_W3: send_w[3] <= avs_writedata_i;
			default: begin
			end
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Sender
always @(posedge clock_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		send_state <= S_IDLE;
		cond_code <= `CC_REJECT;
		xfer_req_o <= 1'b0;
		xfer_addr_o <= 32'h00000000;
		xfer_data_o <= 128'h0;
	end else begin
		case (send_state)
		S_IDLE: begin
			if (go_start) begin
				if (send_internal) begin
					cond_code <= int_load ? `CC_ACCEPT : `CC_REJECT;
					send_state <= S_FIN;
				end else if (in_range(send_addr)) begin
					xfer_req_o <= 1'b1;
					xfer_addr_o <= send_addr;
					xfer_data_o <= {send_w[3], send_w[2], send_w[1], send_w[0]};
					send_state <= S_BUS;
				end else begin
					cond_code <= `CC_REJECT;
					send_state <= S_FIN;
				end
			end
		end
		S_BUS: begin
			if (xfer_done_i) begin
				xfer_req_o <= 1'b0;
				cond_code <= xfer_ack_i ? `CC_ACCEPT : `CC_REJECT;
				send_state <= S_FIN;
			end
		end
		S_FIN: begin
			// Held until the stalled go write is released
			if (!avs_waitrequest_o) begin
				send_state <= S_IDLE;
			end
		end
		default: send_state <= S_IDLE;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////
// Receiver and message execution
always @(posedge clock_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		rx_state <= R_IDLE;
		msg[0] <= 32'h00000000;
		msg[1] <= 32'h00000000;
		msg[2] <= 32'h00000000;
		msg[3] <= 32'h00000000;
		fetch_req_o <= 1'b0;
		servicing_o <= 1'b0;
		pin_irq_o <= 1'b0;
		intr_req_o <= 1'b0;
		intr_vector_o <= 8'h00;
		cache_purge_o <= 1'b0;
		init_start_o <= 1'b0;
		frozen_o <= 1'b0;
		reinit_o <= 1'b0;
		ip_o <= 32'h00000000;
		bp0_o <= 32'h00000000;
		bp1_o <= 32'h00000000;
		bp_en_o <= 2'b00;
		mem_wr_o <= 1'b0;
		mem_addr_o <= 32'h00000000;
		mem_data_o <= 32'h00000000;
		sat <= `SAT_RESET;
		processor_control_block <= `PROCESSOR_CONTROL_BLOCK_RESET;
		pend <= 32'h00000000;
	end else begin
		intr_req_o <= 1'b0;
		cache_purge_o <= 1'b0;
		init_start_o <= 1'b0;
		reinit_o <= 1'b0;
		mem_wr_o <= 1'b0;
		// An internal load starts servicing now, so the pin must stay quiet too
		pin_irq_o <= pin_req && pin_vector != 8'h00 && rx_state == R_IDLE && !int_load;
		case (rx_state)
		R_IDLE: begin
			if (int_load) begin
				msg[0] <= send_w[0];
				msg[1] <= send_w[1];
				msg[2] <= send_w[2];
				msg[3] <= send_w[3];
				servicing_o <= 1'b1;
				rx_state <= R_EXEC;
			end else if (pin_req && pin_vector == 8'h00) begin
				fetch_req_o <= 1'b1;
				servicing_o <= 1'b1;
				rx_state <= R_FETCH;
			end
		end
		R_FETCH: begin
			if (fetch_done_i) begin
				fetch_req_o <= 1'b0;
				msg[0] <= fetch_data_i[31:0];
				msg[1] <= fetch_data_i[63:32];
				msg[2] <= fetch_data_i[95:64];
				msg[3] <= fetch_data_i[127:96];
				rx_state <= R_EXEC;
			end
		end
		R_EXEC: begin
			// No priority check against the message itself
			rx_state <= R_DONE;
			case (msg_type)
			`MT_INTERRUPT: begin
				if (field1_prio > exec_priority_o) begin
					intr_req_o <= 1'b1;
					intr_vector_o <= msg_field1;
				end else begin
					pend[field1_prio] <= 1'b1;
					pend_vec[field1_prio] <= msg_field1;
				end
			end
			`MT_TEST_PEND: begin
				if (best[5] && best[4:0] > exec_priority_o) begin
					intr_req_o <= 1'b1;
					intr_vector_o <= pend_vec[best[4:0]];
					pend[best[4:0]] <= 1'b0;
				end
			end
			`MT_PURGE: cache_purge_o <= 1'b1;
			`MT_SET_BP: begin
				bp_en_o[0] <= ~msg[1][`BP_DISABLE_BIT];
				bp_en_o[1] <= ~msg[2][`BP_DISABLE_BIT];
				if (!msg[1][`BP_DISABLE_BIT]) begin
					bp0_o <= msg[1];
				end
				if (!msg[2][`BP_DISABLE_BIT]) begin
					bp1_o <= msg[2];
				end
			end
			`MT_STORE_BASE: begin
				mem_wr_o <= 1'b1;
				mem_addr_o <= msg[1];
				mem_data_o <= sat;
				rx_state <= R_STORE;
			end
			`MT_FREEZE: frozen_o <= 1'b1;
			`MT_CONT_INIT: begin
				init_start_o <= 1'b1;
				frozen_o <= 1'b0;
			end
			`MT_REINIT: begin
				sat <= msg[1];
				processor_control_block <= msg[2];
				ip_o <= msg[3];
				reinit_o <= 1'b1;
				frozen_o <= 1'b0;
			end
			default: begin
				rx_state <= R_DONE;
			end
			endcase
		end
		R_STORE: begin
			mem_wr_o <= 1'b1;
			mem_addr_o <= mem_addr_o + `STORE_STEP;
			mem_data_o <= processor_control_block;
			rx_state <= R_DONE;
		end
		R_DONE: begin
			servicing_o <= 1'b0;
			rx_state <= R_IDLE;
		end
		default: rx_state <= R_IDLE;
		endcase
	end
end

endmodule

//--- hdl/agent_message_defs.vh
// Constants for the agent message handler: offsets, fields, message types, codes
// Functional notes
// - Each receiving agent holds a unique message address from FF000C00 to FFFFCC00
// - The receiver is picked only by target address bits 14 to 23
// - Target address bits 4 to 8 carry the message priority
// - Sender moves a four-word message to the encoded receiver address in one quad transfer
// - Condition code becomes 010 when accepted and 000 when rejected
// - Sender holds off further instructions until the quad transfer completes
// - Accepted or rejected comes from the acknowledge or non-acknowledge answer
// - First interrupt pin vector of 0 turns that pin into the message request
// - On request read vector bits 0-7; if zero fetch and execute the message
// - Every accepted message runs at once, with no priority comparison
// - Current execution priority is kept visible to the external arbitration logic
// - Servicing handshake lets external logic reject messages until servicing ends
// - Type 92 starts initialisation from the memory image, skipping self test
// - Type 91 puts the device into its stopped state
// - Type 40 interrupts with field 1 vector: serve now if higher, else pend
// - Type 89 invalidates the whole instruction cache
// - Type 93 reinitialises: table from field 3, control block field 4, IP field 5
// - Type 8F loads breakpoints 0 and 1 from fields 3, 4; bit 1 disables
// - Type 80 stores table location at field 3 address, control block at plus 4
// - Type 41 serves the best pending interrupt above current priority, else nothing
// - Each message carries an 8-bit type code naming its action
// - Only the fields a message type needs are examined
// - Interrupt pins are ignored while a message is being handled
// - A quad transfer to FF000010 is an internal message into the own buffer
`ifndef AGENT_MESSAGE_DEFS_VH
`define AGENT_MESSAGE_DEFS_VH

// Register word indices on the bus
`define REG_CTRL 4'h0
`define REG_AGENT_ADDR 4'h1
`define REG_SEND_ADDR 4'h2
`define REG_SEND_W0 4'h3
`define REG_SEND_W1 4'h4
`define REG_SEND_W2 4'h5
`define REG_SEND_W3 4'h6
`define REG_GO 4'h7
`define REG_STATUS 4'h8
`define REG_BP0 4'h9
`define REG_BP1 4'ha
`define REG_SAT 4'hb
`define REG_PROCESSOR_CONTROL_BLOCK 4'hc

// Control register fields
`define CTRL_VEC_LSB 0
`define CTRL_VEC_MSB 7
`define CTRL_PRIO_LSB 8
`define CTRL_PRIO_MSB 12

// Message address decoding
`define ADDR_MIN 32'hff000c00
`define ADDR_MAX 32'hffffcc00
`define ADDR_INTERNAL 32'hff000010
`define ADDR_ID_LSB 14
`define ADDR_ID_MSB 23
`define ADDR_PRIO_LSB 4
`define ADDR_PRIO_MSB 8

// Message word 0 layout, vector priority bits and breakpoint word disable bit
`define MSG_TYPE_LSB 24
`define MSG_TYPE_MSB 31
`define MSG_FIELD1_LSB 16
`define MSG_FIELD1_MSB 23
`define VEC_PRIO_LSB 3
`define VEC_PRIO_MSB 7
`define BP_DISABLE_BIT 1

// Message types
`define MT_INTERRUPT 8'h40
`define MT_TEST_PEND 8'h41
`define MT_STORE_BASE 8'h80
`define MT_SET_BP 8'h8f
`define MT_PURGE 8'h89
`define MT_FREEZE 8'h91
`define MT_CONT_INIT 8'h92
`define MT_REINIT 8'h93

// Condition codes, store address step and reset values
`define CC_ACCEPT 3'h2
`define CC_REJECT 3'h0
`define STORE_STEP 32'h00000004
`define SAT_RESET 32'h00000000
`define PROCESSOR_CONTROL_BLOCK_RESET 32'h00000000

`endif

//--- bench/agent_message_handler_assertions.sv
// Port-level assertions for the agent message handler
`timescale 1ns/1ps
module amh_checker (
	input wire clock_i, // Clock
	input wire rst_n_i, // Reset, active low
	input wire [3:0] avs_address_i, // Word index
	input wire avs_write_i, // Write
	input wire [31:0] avs_writedata_i, // Write data
	input wire avs_waitrequest_o, // Stall
	input wire xfer_req_o, // Send request
	input wire [31:0] xfer_addr_o, // Receiver
	input wire xfer_done_i, // Send over
	input wire first_interrupt_pin_n_i, // Request pin
	input wire fetch_req_o, // Fetch
	input wire fetch_done_i, // Fetched
	input wire [127:0] fetch_data_i, // Message words
	input wire servicing_o, // Handling
	input wire [4:0] exec_priority_o, // Priority
	input wire pin_irq_o, // Plain interrupt
	input wire intr_req_o, // Serve now
	input wire cache_purge_o, // Purge
	input wire init_start_o, // Init start
	input wire frozen_o, // Stopped
	input wire reinit_o, // Reinitialise
	input wire [1:0] bp_en_o, // Breakpoint enables
	input wire mem_wr_o, // Store
	input wire [31:0] mem_addr_o // Store address
);
	wire [7:0] msg_type = fetch_data_i[31:24];
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////////////////////////////
	send_held_a: assert property (xfer_req_o && !xfer_done_i |=> xfer_req_o && $stable(xfer_addr_o))
		else $error("send request dropped early");
	pin_quiet_a: assert property (servicing_o |-> !pin_irq_o)
		else $error("pin interrupt while servicing");
	fetch_cause_a: assert property ($rose(fetch_req_o) |-> servicing_o && $past(!first_interrupt_pin_n_i))
		else $error("fetch without pin request");
	prio_shown_a: assert property (avs_write_i && avs_address_i == 4'h0 && !avs_waitrequest_o
		|=> ##1 exec_priority_o == $past(avs_writedata_i[12:8], 2)) else $error("priority not shown");
	serv_end_a: assert property ($fell(fetch_req_o) |-> servicing_o [*2] ##[1:2] !servicing_o)
		else $error("servicing span wrong");
	bp_set_a: assert property (fetch_done_i && msg_type == 8'h8f
		|-> ##2 bp_en_o == ~{$past(fetch_data_i[65], 2), $past(fetch_data_i[33], 2)}) else $error("bp enables");
	purge_pulse_a: assert property (fetch_done_i && msg_type == 8'h89 |-> ##2 cache_purge_o)
		else $error("no purge");
	store_base_a: assert property (fetch_done_i && msg_type == 8'h80 |-> ##2 mem_wr_o
		&& mem_addr_o == $past(fetch_data_i[63:32], 2) ##1 mem_wr_o
		&& mem_addr_o == $past(fetch_data_i[63:32], 3) + 32'h4) else $error("store base");
	freeze_set_a: assert property (fetch_done_i && msg_type == 8'h91 |-> ##2 frozen_o)
		else $error("no freeze");
	init_start_a: assert property (fetch_done_i && msg_type == 8'h92 |-> ##2 init_start_o)
		else $error("no init start");
	drop_unknown_a: assert property (fetch_done_i && msg_type == 8'h55
		|-> ##2 !(cache_purge_o || init_start_o || mem_wr_o || intr_req_o)) else $error("unknown type acted");
	intr_now_a: assert property (fetch_done_i && msg_type == 8'h40
		|-> ##2 intr_req_o == ($past(fetch_data_i[23:19], 2) > exec_priority_o)) else $error("interrupt decision");
	reinit_pulse_a: assert property (fetch_done_i && msg_type == 8'h93 |-> ##2 reinit_o)
		else $error("no reinit pulse");
endmodule
bind agent_message_handler amh_checker i_amh_checker (.*);

//--- bench/msg_bus_model.sv
// Bus and arbitration model facing the message handler
`timescale 1ns/1ps
module msg_bus_model (
	input wire clock_i, // Clock
	input wire xfer_req_i, // Send request
	input wire [31:0] xfer_addr_i, // Encoded receiver
	output reg xfer_done_o = 1'b0, // Send over
	output reg xfer_ack_o = 1'b0, // Accepted
	input wire fetch_req_i, // Fetch request
	output reg fetch_done_o = 1'b0, // Words valid
	output wire [127:0] fetch_data_o, // Message words
	output reg pin_n_o = 1'b1, // Request pin
	input wire [4:0] rx_prio_i, // Far receiver priority
	input wire [127:0] msg_i, // Message to deliver
	input wire post_i, // Deliver now
	input wire [1:0] lag_i // Answer delay
);
	reg [1:0] n = 2'h0;
	// Words outside the valid cycle are inverted, never left stale
	assign fetch_data_o = fetch_done_o ? msg_i : ~msg_i;
	always @(posedge clock_i) begin
		xfer_done_o <= 0;
		fetch_done_o <= 0;
		xfer_ack_o <= ~xfer_ack_o;
		if (post_i)
			pin_n_o <= 0;
		if ((xfer_req_i && !xfer_done_o) || (fetch_req_i && !fetch_done_o)) begin
			n <= n + 2'h1;
			if (n == lag_i) begin
				n <= 0;
				if (xfer_req_i) begin
					xfer_done_o <= 1;
					xfer_ack_o <= xfer_addr_i[8:4] > rx_prio_i;
				end else begin
					fetch_done_o <= 1;
					pin_n_o <= 1;
				end
			end
		end
	end
endmodule

//--- bench/test_agent_message_handler.sv
// Self-checking bench for the agent message handler
`timescale 1ns/1ps
module test_agent_message_handler;
	reg clock_i, rst_n_i, avs_read_i, avs_write_i, post;
	reg [3:0] avs_address_i;
	reg [31:0] avs_writedata_i, q;
	reg [127:0] words;
	reg [4:0] rx_prio;
	reg [1:0] lag;
	integer n_mismatch, checked;
	wire xfer_done_i, xfer_ack_i, first_interrupt_pin_n_i, fetch_done_i;
	wire [127:0] fetch_data_i, xfer_data_o;
	wire [31:0] avs_readdata_o, xfer_addr_o, ip_o, bp0_o, bp1_o, mem_addr_o, mem_data_o;
	wire avs_waitrequest_o, xfer_req_o, fetch_req_o, servicing_o, pin_irq_o, intr_req_o;
	wire cache_purge_o, init_start_o, frozen_o, reinit_o, mem_wr_o;
	wire [4:0] exec_priority_o;
	wire [9:0] agent_id_o;
	wire [7:0] intr_vector_o;
	wire [1:0] bp_en_o;
	agent_message_handler i_agent_message_handler (.*);
	msg_bus_model i_msg_bus_model (.clock_i(clock_i), .xfer_req_i(xfer_req_o), .xfer_addr_i(xfer_addr_o),
		.xfer_done_o(xfer_done_i), .xfer_ack_o(xfer_ack_i), .fetch_req_i(fetch_req_o),
		.fetch_done_o(fetch_done_i), .fetch_data_o(fetch_data_i), .pin_n_o(first_interrupt_pin_n_i),
		.rx_prio_i(rx_prio), .msg_i(words), .post_i(post), .lag_i(lag));
	////////////////////////////////////////////////////////////////
	task chk(input [8*6-1:0] nm, input [31:0] s, input [31:0] e);
	begin
		checked = checked + 1;
		if (s !== e) begin
			n_mismatch = n_mismatch + 1;
			$display("BAD %0s expected %h seen %h", nm, e, s);
		end
	end
	endtask
	task acc(input w, input [3:0] a, input [31:0] d);
	begin
		@(posedge clock_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		@(posedge clock_i);
		while (avs_waitrequest_o)
			@(posedge clock_i);
		q = avs_readdata_o;
		avs_write_i <= 0;
		avs_read_i <= 0;
	end
	endtask
	task send(input [31:0] a, input [4:0] p, input [1:0] l, input [31:0] e);
	begin
		rx_prio <= p;
		lag <= l;
		acc(1, 4'h2, a);
		acc(1, 4'h7, 32'h0);
		acc(0, 4'h8, 32'h0);
		chk("status", q, e);
	end
	endtask
	task post_msg(input [7:0] t, input [7:0] v, input [31:0] f3, input [31:0] f4, input [31:0] f5);
	begin
		@(posedge clock_i);
		words <= {f5, f4, f3, t, v, 16'h0};
		post <= 1;
		@(posedge clock_i);
		post <= 0;
	end
	endtask
	task rx(input [7:0] t, input [7:0] v, input [31:0] f3, input [31:0] f4, input [31:0] f5);
	begin
		post_msg(t, v, f3, f4, f5);
		@(negedge servicing_o);
		@(posedge clock_i);
	end
	endtask
	task stop_test;
	begin
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clock_i = 0;
		forever #5 clock_i = ~clock_i;
	end
	initial begin
		repeat (20000) @(posedge clock_i);
		n_mismatch = n_mismatch + 1;
		stop_test;
	end
	initial begin
		{rst_n_i, avs_read_i, avs_write_i, post, avs_address_i, avs_writedata_i} = 0;
		{words, rx_prio, lag, n_mismatch, checked} = 0;
		repeat (4) @(posedge clock_i);
		rst_n_i <= 1;
		acc(0, 4'h1, 32'h0);
		chk("agent", q, 32'hff000c00);
		acc(1, 4'h0, 32'h0a33);
		acc(1, 4'h1, 32'hff004d90);
		acc(1, 4'h1, 32'hffffd000);
		acc(0, 4'h1, 32'h0);
		chk("agent", q, 32'hff004d90);
		chk("id", agent_id_o, 32'h1);
		chk("prio", exec_priority_o, 32'ha);
		acc(0, 4'hf, 32'h0);
		chk("unmap", q, 32'h0);
		acc(1, 4'h3, 32'h89000000);
		send(32'hff004d90, 5'ha, 2'h0, 32'h00190042);
		chk("tprio", q[20:16], 32'h19);
		chk("tid", q[15:6], 32'h1);
		chk("xaddr", xfer_addr_o, 32'hff004d90);
		chk("xdata", xfer_data_o[31:0], 32'h89000000);
		send(32'hff004d90, 5'h19, 2'h2, 32'h00190040);
		send(32'hff000800, 5'h0, 2'h0, 32'h0);
		send(32'hff000010, 5'h1f, 2'h3, 32'h00010002);
		post_msg(8'h55, 8'h0, 32'h0, 32'h0, 32'h0);
		repeat (3) @(posedge clock_i);
		chk("pinirq", pin_irq_o, 32'h1);
		chk("fetch", fetch_req_o, 32'h0);
		acc(1, 4'h0, 32'h0a00);
		@(negedge servicing_o);
		rx(8'h8f, 8'hff, 32'h1000, 32'h2002, 32'hffffffff);
		chk("bp0", bp0_o, 32'h1000);
		chk("bpen", bp_en_o, 32'h1);
		chk("bp1", bp1_o, 32'h0);
		rx(8'h93, 8'h0, 32'h400, 32'h800, 32'h1234);
		chk("ip", ip_o, 32'h1234);
		acc(0, 4'hb, 32'h0);
		chk("sat", q, 32'h400);
		acc(0, 4'hc, 32'h0);
		chk("ctlblk", q, 32'h800);
		rx(8'h80, 8'h0, 32'h100, 32'h0, 32'h0);
		chk("maddr", mem_addr_o, 32'h104);
		chk("mdata", mem_data_o, 32'h800);
		rx(8'h89, 8'h0, 32'h0, 32'h0, 32'h0);
		rx(8'h91, 8'h0, 32'h0, 32'h0, 32'h0);
		chk("frozen", frozen_o, 32'h1);
		rx(8'h92, 8'h0, 32'h0, 32'h0, 32'h0);
		chk("frozen", frozen_o, 32'h0);
		rx(8'h40, 8'hf8, 32'h0, 32'h0, 32'h0);
		chk("vector", intr_vector_o, 32'hf8);
		rx(8'h40, 8'h20, 32'h0, 32'h0, 32'h0);
		chk("vector", intr_vector_o, 32'hf8);
		acc(1, 4'h0, 32'h0200);
		rx(8'h41, 8'h0, 32'h0, 32'h0, 32'h0);
		chk("vector", intr_vector_o, 32'h20);
		stop_test;
	end
endmodule
